//--- design/ofd_defs.svh
/*
  Constants of the operand field decoder: stream geometry, field positions,
  reset values and register-use limits.
  Assumes inclusion by bare name from the package and design modules.
*/
`ifndef OFD_DEFS_SVH
`define OFD_DEFS_SVH

`define OFD_NUM_BYTES      10
`define OFD_BYTE_W         8
`define OFD_STREAM_W       80
`define OFD_IDX_W          4
`define OFD_NIB_W          5
`define OFD_SLOTS          16
`define OFD_SMALL_IMM_LSB  4
`define OFD_LMOVE_BYTE     3
`define OFD_LMOVE_BIT      7
`define OFD_TEST_SET_OK_MASK 8'h33
`define OFD_MULTI_LAST_REG 4'h6
`define OFD_RESET_WORD     32'h0000_0000
`define OFD_RESET_REG      3'h0

`endif

//--- design/ofd_pkg.sv
/*
  Types of the operand field decoder: operand sizes, operand widths and
  register parts.
  Assumes the constants header is on the include path.
*/
`include "ofd_defs.svh"

package ofd_pkg;

  typedef enum logic [2:0] {
    OFD_SIZE_BYTE = 3'b001,
    OFD_SIZE_WORD = 3'b010,
    OFD_SIZE_LONG = 3'b100
  } ofd_size_t;

  typedef enum logic [2:0] {
    OFD_IMM_NONE = 3'h0,
    OFD_IMM_2    = 3'h1,
    OFD_IMM_3    = 3'h2,
    OFD_IMM_8    = 3'h3,
    OFD_IMM_16   = 3'h4,
    OFD_IMM_32   = 3'h5
  } ofd_imm_t;

  typedef enum logic [2:0] {
    OFD_ABS_NONE = 3'h0,
    OFD_ABS_8    = 3'h1,
    OFD_ABS_16   = 3'h2,
    OFD_ABS_24   = 3'h3,
    OFD_ABS_32   = 3'h4
  } ofd_abs_t;

  typedef enum logic [1:0] {
    OFD_DISP_NONE = 2'h0,
    OFD_DISP_8    = 2'h1,
    OFD_DISP_16   = 2'h2,
    OFD_DISP_32   = 2'h3
  } ofd_disp_t;

  typedef enum logic [2:0] {
    OFD_FULL           = 3'h0,
    OFD_HALF_LOW       = 3'h1,
    OFD_HALF_UPPER     = 3'h2,
    OFD_HALF_HIGH_BYTE = 3'h3,
    OFD_HALF_LOW_BYTE  = 3'h4
  } ofd_part_t;

endpackage

//--- design/ofd_reg_map.sv
/*
  Maps one register-select field onto a general register and the part of it
  that the operand uses.
  Assumes the caller gives the operand size of the instruction form.
*/
`include "ofd_defs.svh"

module ofd_reg_map (
  input  wire logic [3:0]        field,
  input  wire ofd_pkg::ofd_size_t op_size,
  output logic      [2:0]        reg_idx,
  output ofd_pkg::ofd_part_t     part
);
  import ofd_pkg::*;

  always_comb begin
    reg_idx = field[2:0];
    case (op_size)
      OFD_SIZE_BYTE: begin
        part = field[3] ? OFD_HALF_LOW_BYTE : OFD_HALF_HIGH_BYTE;
      end
      OFD_SIZE_WORD: begin
        part = field[3] ? OFD_HALF_UPPER : OFD_HALF_LOW;
      end
      default: begin
        // Long fields carry three bits; the fourth, field[3], is ignored.
        part = OFD_FULL;
      end
    endcase
  end

endmodule // ofd_reg_map

//--- design/ofd_decoder.sv
/*
  Operand field decoder: extracts immediate, absolute-address and
  displacement operands and register selections from a buffered instruction.
  Assumes the opcode decoder supplies operand size, operand widths, byte and
  nibble positions of each field, and a pipeline advance strobe.
*/
`include "ofd_defs.svh"

// Functional notes
// - Immediates of 2, 3, 8, 16, 32 bits.
// - Absolute addresses of 8, 16, 24, 32 bits.
// - Displacements of 8, 16 or 32 bits.
// - Three-bit field selects full register 0-7.
// - Word field: 0-7 low, 8-15 upper half.
// - Byte field: 0-7 high, 8-15 low byte.
// - Long move: ignore fourth byte bit 7.
module ofd_decoder #(
  parameter int NUM_BYTES = `OFD_NUM_BYTES
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic [NUM_BYTES*8-1:0]  instr_bytes,
  input  wire logic                    instr_valid,
  input  wire logic                    pipe_advance,
  input  wire ofd_pkg::ofd_size_t      op_size,
  input  wire ofd_pkg::ofd_imm_t       imm_sel,
  input  wire logic [3:0]              imm_idx,
  input  wire ofd_pkg::ofd_abs_t       abs_sel,
  input  wire logic [3:0]              abs_idx,
  input  wire ofd_pkg::ofd_disp_t      disp_sel,
  input  wire logic [3:0]              disp_idx,
  input  wire logic [4:0]              dst_nib,
  input  wire logic [4:0]              src_nib,
  input  wire logic                    src_used,
  input  wire logic                    long_move_op,
  input  wire logic                    atomic_test_set_op,
  input  wire logic                    multi_reg_store_op,
  input  wire logic                    multi_reg_load_op,
  input  wire logic [1:0]              multi_cnt,
  output logic                         dec_valid_q,
  output logic [31:0]                  immediate_operand_q,
  output ofd_pkg::ofd_imm_t            imm_width_q,
  output logic [31:0]                  abs_addr_q,
  output ofd_pkg::ofd_abs_t            abs_width_q,
  output logic [31:0]                  disp_q,
  output ofd_pkg::ofd_disp_t           disp_width_q,
  output logic [2:0]                   dst_reg_q,
  output ofd_pkg::ofd_part_t           dst_part_q,
  output logic [2:0]                   src_reg_q,
  output ofd_pkg::ofd_part_t           src_part_q,
  output logic                         src_used_q,
  output logic                         test_set_reg_warn_q,
  output logic                         multi_reg_warn_q
);
  import ofd_pkg::*;

  logic [NUM_BYTES*8-1:0] stream_m;
  logic [7:0]             slot [0:`OFD_SLOTS-1];
  logic [3:0]             dst_field;
  logic [3:0]             src_field;
  logic [2:0]             dst_reg_d;
  logic [2:0]             src_reg_d;
  ofd_part_t              dst_part_d;
  ofd_part_t              src_part_d;
  logic [31:0]            imm_d;
  logic [31:0]            abs_d;
  logic [31:0]            disp_d;
  logic                   test_set_warn_d;
  logic                   multi_warn_d;
  logic [3:0]             multi_last;
  logic                   take;

  // The fourth byte's top bit is a don't-care for the long move form, so it
  // is cleared before any field is cut from the stream.
  always_comb begin
    stream_m = instr_bytes;
    if (long_move_op) begin
      stream_m[NUM_BYTES*8-1-`OFD_LMOVE_BYTE*8-(`OFD_BYTE_W-1-`OFD_LMOVE_BIT)] = 1'b0;
    end
  end

  // Byte slots, first instruction byte in slot 0; slots past the end read 0.
  for (genvar g = 0; g < `OFD_SLOTS; g++) begin : g_slot
    if (g < NUM_BYTES) begin : g_live
      assign slot[g] = stream_m[NUM_BYTES*8-1-g*8 -: 8];
    end else begin : g_pad
      assign slot[g] = 8'h00;
    end
  end

  // Byte k of the stream; zero past the last byte, so long fields never wrap.
  function automatic logic [7:0] byte_at(input logic [4:0] k);
    return (k < 5'(NUM_BYTES)) ? slot[k[3:0]] : 8'h00;
  endfunction

  // Four big-endian bytes from a start slot, then kept to nb bytes.
  function automatic logic [31:0] field_at(input logic [3:0] idx, input logic [2:0] nb);
    logic [31:0] w;
    logic [4:0]  k;
    k = {1'b0, idx};
    w = {byte_at(k), byte_at(k + 5'h01), byte_at(k + 5'h02), byte_at(k + 5'h03)};
    return w >> (6'(3'h4 - nb) * 6'h08);
  endfunction

  // Nibble n of the stream, even n being a byte's high nibble.
  function automatic logic [3:0] nib_at(input logic [4:0] n);
    logic [7:0] b;
    b = slot[n[4:1]];
    return n[0] ? b[3:0] : b[7:4];
  endfunction

  always_comb begin
    imm_d = `OFD_RESET_WORD;
    case (imm_sel)
      OFD_IMM_2:  imm_d = {30'h0, slot[imm_idx][`OFD_SMALL_IMM_LSB +: 2]};
      OFD_IMM_3:  imm_d = {29'h0, slot[imm_idx][`OFD_SMALL_IMM_LSB +: 3]};
      OFD_IMM_8:  imm_d = field_at(imm_idx, 3'h1);
      OFD_IMM_16: imm_d = field_at(imm_idx, 3'h2);
      OFD_IMM_32: imm_d = field_at(imm_idx, 3'h4);
      default:    imm_d = `OFD_RESET_WORD;
    endcase
  end

  always_comb begin
    abs_d = `OFD_RESET_WORD;
    case (abs_sel)
      OFD_ABS_8:  abs_d = field_at(abs_idx, 3'h1);
      OFD_ABS_16: abs_d = field_at(abs_idx, 3'h2);
      OFD_ABS_24: abs_d = field_at(abs_idx, 3'h3);
      OFD_ABS_32: abs_d = field_at(abs_idx, 3'h4);
      default:    abs_d = `OFD_RESET_WORD;
    endcase
  end

  always_comb begin
    disp_d = `OFD_RESET_WORD;
    case (disp_sel)
      OFD_DISP_8:  disp_d = field_at(disp_idx, 3'h1);
      OFD_DISP_16: disp_d = field_at(disp_idx, 3'h2);
      OFD_DISP_32: disp_d = field_at(disp_idx, 3'h4);
      default:     disp_d = `OFD_RESET_WORD;
    endcase
  end

  // A process, not an assign, so that a change of the stream alone re-evaluates.
  always_comb begin
    dst_field = nib_at(dst_nib);
    src_field = nib_at(src_nib);
  end

  ofd_reg_map u_dst_map (
    .field   (dst_field),
    .op_size (op_size),
    .reg_idx (dst_reg_d),
    .part    (dst_part_d)
  );

  ofd_reg_map u_src_map (
    .field   (src_field),
    .op_size (op_size),
    .reg_idx (src_reg_d),
    .part    (src_part_d)
  );

  // Software is expected to keep these limits; the flags only report misuse.
  assign test_set_warn_d = atomic_test_set_op
                           && (((`OFD_TEST_SET_OK_MASK >> dst_reg_d) & 8'h01) == 8'h00);
  // The list runs from the base register up to base plus count.
  assign multi_last   = {1'b0, dst_reg_d} + {2'b00, multi_cnt};
  assign multi_warn_d = (multi_reg_store_op || multi_reg_load_op)
                        && (multi_last > `OFD_MULTI_LAST_REG);

  assign take = pipe_advance && instr_valid;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dec_valid_q <= 1'b0;
    end else if (pipe_advance) begin
      dec_valid_q <= instr_valid;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      immediate_operand_q <= `OFD_RESET_WORD;
      imm_width_q         <= OFD_IMM_NONE;
      abs_addr_q          <= `OFD_RESET_WORD;
      abs_width_q         <= OFD_ABS_NONE;
      disp_q              <= `OFD_RESET_WORD;
      disp_width_q        <= OFD_DISP_NONE;
    end else if (take) begin
      immediate_operand_q <= imm_d;
      imm_width_q         <= imm_sel;
      abs_addr_q          <= abs_d;
      abs_width_q         <= abs_sel;
      disp_q              <= disp_d;
      disp_width_q        <= disp_sel;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dst_reg_q  <= `OFD_RESET_REG;
      dst_part_q <= OFD_FULL;
      src_reg_q  <= `OFD_RESET_REG;
      src_part_q <= OFD_FULL;
      src_used_q <= 1'b0;
    end else if (take) begin
      dst_reg_q  <= dst_reg_d;
      dst_part_q <= dst_part_d;
      src_reg_q  <= src_reg_d;
      src_part_q <= src_part_d;
      src_used_q <= src_used;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      test_set_reg_warn_q <= 1'b0;
      multi_reg_warn_q    <= 1'b0;
    end else if (pipe_advance) begin
      test_set_reg_warn_q <= instr_valid && test_set_warn_d;
      multi_reg_warn_q <= instr_valid && multi_warn_d;
    end
  end

endmodule // ofd_decoder

//--- verif/ofd_properties.sv
/*
  Port checks of the operand field decoder.
  Assumes a bind onto the decoder with named connections.
*/
module ofd_properties #(
  parameter int NUM_BYTES = 10
) (
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire logic [NUM_BYTES*8-1:0] instr_bytes,
  input wire logic                   instr_valid,
  input wire logic                   pipe_advance,
  input wire ofd_pkg::ofd_size_t     op_size,
  input wire ofd_pkg::ofd_imm_t      imm_sel,
  input wire ofd_pkg::ofd_abs_t      abs_sel,
  input wire ofd_pkg::ofd_disp_t     disp_sel,
  input wire logic [4:0]             dst_nib,
  input wire logic                   dec_valid_q,
  input wire ofd_pkg::ofd_imm_t      imm_width_q,
  input wire ofd_pkg::ofd_abs_t      abs_width_q,
  input wire ofd_pkg::ofd_disp_t     disp_width_q,
  input wire logic [2:0]             dst_reg_q,
  input wire ofd_pkg::ofd_part_t     dst_part_q
);
  timeunit 1ns;
  timeprecision 1ps;
  import ofd_pkg::*;
  logic [2:0] dreg;
  logic       dhi;
  logic       tk;
  assign {dhi, dreg} = instr_bytes[NUM_BYTES*8-1-4*dst_nib -: 4];
  assign tk = pipe_advance && instr_valid;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_VALID: assert property (pipe_advance |=> dec_valid_q == $past(instr_valid))
    else $error("valid flag wrong");
  AST_HOLD: assert property (!pipe_advance |=> $stable(dec_valid_q) && $stable(dst_part_q))
    else $error("outputs moved without advance");
  AST_IMM_W: assert property (tk |=> imm_width_q == $past(imm_sel))
    else $error("immediate width wrong");
  AST_ABS_W: assert property (tk |=> abs_width_q == $past(abs_sel))
    else $error("address width wrong");
  AST_DISP_W: assert property (tk |=> disp_width_q == $past(disp_sel))
    else $error("displacement width wrong");
  AST_FULL: assert property (tk && op_size == OFD_SIZE_LONG |=>
    dst_part_q == OFD_FULL && dst_reg_q == $past(dreg)) else $error("full register wrong");
  AST_WORD: assert property (tk && op_size == OFD_SIZE_WORD |=> dst_reg_q == $past(dreg) &&
    dst_part_q == ($past(dhi) ? OFD_HALF_UPPER : OFD_HALF_LOW)) else $error("half wrong");
  AST_BYTE: assert property (tk && op_size == OFD_SIZE_BYTE |=> dst_reg_q == $past(dreg) &&
    dst_part_q == ($past(dhi) ? OFD_HALF_LOW_BYTE : OFD_HALF_HIGH_BYTE)) else $error("byte wrong");
endmodule // ofd_properties

//--- verif/ofd_fetch_model.sv
/*
  Fetch-side model: shows a whole instruction, or a released buffer.
  Assumes fill and word change away from the rising edge.
*/
module ofd_fetch_model (
  input  wire logic        sys_clk,
  input  wire logic        fill,
  input  wire logic [79:0] word,
  output logic [79:0]      instr_bytes,
  output logic             instr_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [79:0] last_q;
  always_ff @(posedge sys_clk) begin
    if (fill) begin
      last_q <= word;
    end
  end
  // A released buffer shows the inverse of its last contents.
  assign instr_bytes = fill ? word : ~last_q;
  assign instr_valid = fill;
endmodule // ofd_fetch_model

//--- verif/operand_field_decoder_tb.sv
/*
  Random and directed checks of the operand field decoder.
  Assumes the fetch model feeds the instruction buffer.
*/
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin errors++; \
  $display("unexpected %s: expected %h, seen %h", n, e, s); end end
module operand_field_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ofd_pkg::*;
  logic        sys_clk = 1'b0, rst = 1'b1, fill, pipe_advance, src_used, long_move_op;
  logic        atomic_test_set_op, multi_reg_store_op, multi_reg_load_op, instr_valid;
  logic        dec_valid_q, src_used_q, test_set_reg_warn_q, multi_reg_warn_q, e_dv, e_tw;
  logic        e_mw, e_su;
  logic [79:0] word, instr_bytes;
  logic [31:0] immediate_operand_q, abs_addr_q, disp_q, e_imm, e_abs, e_disp, r, q;
  logic [3:0]  imm_idx, abs_idx, disp_idx, f;
  logic [4:0]  dst_nib, src_nib;
  logic [2:0]  dst_reg_q, src_reg_q, e_dr, e_sr;
  logic [1:0]  multi_cnt;
  ofd_size_t   op_size;
  ofd_imm_t    imm_sel, imm_width_q, e_iw;
  ofd_abs_t    abs_sel, abs_width_q, e_aw;
  ofd_disp_t   disp_sel, disp_width_q, e_dw;
  ofd_part_t   dst_part_q, src_part_q, e_dp, e_sp;
  int          errors = 0, num_checks = 0, seed = 32'hFA7C0E74;

  ofd_fetch_model u_fetch (.*);
  ofd_decoder u_dut (.*);

  always #12.5 sys_clk = ~sys_clk;

  function automatic logic [31:0] fld(logic [79:0] w, int k, int n);
    logic [31:0] v = 32'h0;
    for (int i = 0; i < n; i++) begin
      v = {v[23:0], (k + i < 10) ? w[79-8*(k+i) -: 8] : 8'h00};
    end
    return v;
  endfunction

  function automatic ofd_part_t prt(ofd_size_t s, logic hi);
    if (s == OFD_SIZE_LONG) return OFD_FULL;
    if (s == OFD_SIZE_WORD) return hi ? OFD_HALF_UPPER : OFD_HALF_LOW;
    return hi ? OFD_HALF_LOW_BYTE : OFD_HALF_HIGH_BYTE;
  endfunction

  task automatic clr();
    {e_dv, e_tw, e_mw, e_su, e_imm, e_abs, e_disp, e_dr, e_sr} = '0;
    e_iw = OFD_IMM_NONE;
    e_aw = OFD_ABS_NONE;
    e_dw = OFD_DISP_NONE;
    e_dp = OFD_FULL;
    e_sp = OFD_FULL;
  endtask

  task automatic rnd();
    word = {32'($random(seed)), 32'($random(seed)), 16'($random(seed))};
    r = $random(seed);
    q = $random(seed);
    op_size = ofd_size_t'(3'h1 << (r[1:0] % 2'd3));
    imm_sel = ofd_imm_t'(r[4:2] % 3'd6);
    abs_sel = ofd_abs_t'(r[7:5] % 3'd5);
    disp_sel = ofd_disp_t'(r[9:8]);
    {imm_idx, abs_idx, disp_idx} = r[21:10];
    dst_nib = r[26:22] % 5'd20;
    src_nib = q[4:0] % 5'd20;
    src_used = q[5];
    multi_cnt = q[7:6];
    // Register choices are drawn freely so that off-limits use is seen.
    atomic_test_set_op = q[9:8] == 2'h1;
    multi_reg_store_op = q[9:8] == 2'h2;
    multi_reg_load_op = q[9:8] == 2'h3;
    long_move_op = q[10] && op_size == OFD_SIZE_LONG;
    pipe_advance = q[13:11] != 3'h0;
    fill = q[15:14] != 2'h0;
  endtask

  task automatic step();
    logic [79:0] x;
    int nb[6] = '{0, 0, 0, 1, 2, 4};
    x = word;
    if (long_move_op) x[55] = 1'b0;
    if (pipe_advance) begin
      e_dv = fill;
      e_tw = 1'b0;
      e_mw = 1'b0;
      if (fill) begin
        e_imm = fld(x, imm_idx, nb[imm_sel]);
        if (imm_sel == OFD_IMM_2) e_imm = (fld(x, imm_idx, 1) >> 4) & 32'h3;
        if (imm_sel == OFD_IMM_3) e_imm = (fld(x, imm_idx, 1) >> 4) & 32'h7;
        e_abs = fld(x, abs_idx, abs_sel);
        e_disp = fld(x, disp_idx, (disp_sel == OFD_DISP_32) ? 4 : disp_sel);
        e_iw = imm_sel;
        e_aw = abs_sel;
        e_dw = disp_sel;
        f = x[79-4*dst_nib -: 4];
        e_dr = f[2:0];
        e_dp = prt(op_size, f[3]);
        f = x[79-4*src_nib -: 4];
        e_sr = f[2:0];
        e_sp = prt(op_size, f[3]);
        e_su = src_used;
        e_tw = atomic_test_set_op && ((8'h33 & (8'h01 << e_dr)) == 8'h00);
        e_mw = (multi_reg_store_op || multi_reg_load_op) && (int'(e_dr) + int'(multi_cnt) > 6);
      end
    end
    @(negedge sys_clk);
    `CHK("valid", e_dv, dec_valid_q)
    `CHK("imm", e_imm, immediate_operand_q)
    `CHK("imm width", e_iw, imm_width_q)
    `CHK("abs", e_abs, abs_addr_q)
    `CHK("abs width", e_aw, abs_width_q)
    `CHK("disp", e_disp, disp_q)
    `CHK("disp width", e_dw, disp_width_q)
    `CHK("dst reg", e_dr, dst_reg_q)
    `CHK("dst part", e_dp, dst_part_q)
    `CHK("src reg", e_sr, src_reg_q)
    `CHK("src part", e_sp, src_part_q)
    `CHK("src used", e_su, src_used_q)
    `CHK("test-set warn", e_tw, test_set_reg_warn_q)
    `CHK("multi warn", e_mw, multi_reg_warn_q)
  endtask

  task automatic end_sim();
    $display("checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    rnd();
    pipe_advance = 1'b0;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    clr();
    step();
    for (int n = 0; n < 800; n++) begin
      rnd();
      step();
    end
    // All-ones long move; the address field runs past the last byte.
    {word, fill, pipe_advance, long_move_op, op_size} = {80'hFFFF_FFFF_FFFF_FFFF_FFFF, 3'h7, OFD_SIZE_LONG};
    {imm_sel, imm_idx, abs_sel, abs_idx} = {OFD_IMM_32, 4'h2, OFD_ABS_32, 4'h8};
    step();
    `CHK("long move imm", 32'hFF7FFFFF, immediate_operand_q)
    `CHK("abs past end", 32'hFFFF0000, abs_addr_q)
    rst = 1'b1;
    pipe_advance = 1'b0;
    @(negedge sys_clk);
    rst = 1'b0;
    clr();
    step();
    end_sim();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    end_sim();
  end
endmodule // operand_field_decoder_tb

bind ofd_decoder ofd_properties #(.NUM_BYTES(NUM_BYTES)) u_props (.*);
